// [hw/timer_capture_defines.svh]
`ifndef TIMER_CAPTURE_DEFINES_SVH
`define TIMER_CAPTURE_DEFINES_SVH

// Register file addresses
`define PTR_ADDR         8'hfd
`define WINDOW_GROUP     4'h0
`define TIMER_BANK       4'hd

// Bank D offsets
`define OFS_HOLD16_HI    4'h7
`define OFS_CAP16_LO     4'h8
`define OFS_CAP16_HI     4'h9
`define OFS_CAP8_LO      4'ha
`define OFS_CAP8_HI      4'hb

// Field positions of the bank group pointer
`define PTR_GROUP_MSB    7
`define PTR_GROUP_LSB    4
`define PTR_BANK_MSB     3
`define PTR_BANK_LSB     0

// Reset values
`define PTR_RESET        8'h00
`define CAP_RESET        8'h00
`define HOLD_RESET       8'h00
`define COUNT_RESET      16'h0000

// Counter constants
`define COUNT_FULL       16'hffff
`define COUNT_ZERO       16'h0000
`define COUNT_LAST       16'h0001

`endif

// [hw/timer_capture_pkg.sv]
package timer_capture_pkg;

    // Sixteen-bit counter sequencing, Gray along idle -> wait -> count
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_COUNT = 2'b11
    } cnt_state_e;

    // Capture and hold storage
    typedef struct packed {
        logic [7:0] hold16_hi;
        logic [7:0] cap16_lo;
        logic [7:0] cap16_hi;
        logic [7:0] cap8_lo;
        logic [7:0] cap8_hi;
        logic [7:0] rdata;
    } store_s;

    // Main block state
    typedef struct packed {
        logic [7:0]  bank_group_pointer;
        logic [15:0] count;
        logic [15:0] init;
        cnt_state_e  st;
        logic        timeout;
        logic        captured;
        logic        rd_tmr;
        logic        rd_valid;
        logic [7:0]  rd_local;
    } main_s;

endpackage : timer_capture_pkg

// [hw/capture_bus_if.sv]
`timescale 1ns/100ps
interface capture_bus_if;
    logic        wr_en;
    logic        rd_en;
    logic [3:0]  offset;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  hold16_hi;
    logic        cap16_stb;
    logic [15:0] cap16_val;
    logic        cap8_hi_stb;
    logic        cap8_lo_stb;
    logic [7:0]  cap8_val;

    modport ctrl  (output wr_en, rd_en, offset, wdata, cap16_stb, cap16_val,
                   cap8_hi_stb, cap8_lo_stb, cap8_val,
                   input  rdata, hold16_hi);
    modport store (input  wr_en, rd_en, offset, wdata, cap16_stb, cap16_val,
                   cap8_hi_stb, cap8_lo_stb, cap8_val,
                   output rdata, hold16_hi);
endinterface : capture_bus_if

// [hw/capture_store.sv]
`timescale 1ns/100ps
`include "timer_capture_defines.svh"
module capture_store
    import timer_capture_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    rst,
    capture_bus_if.store bus
);
    store_s s_q;
    store_s s_d;

    assign bus.rdata     = s_q.rdata;
    assign bus.hold16_hi = s_q.hold16_hi;

    // Hardware strobes load captures; the bus may only touch the hold byte
    always_comb begin
        s_d = s_q;
        if (bus.wr_en && bus.offset == `OFS_HOLD16_HI) begin
            s_d.hold16_hi = bus.wdata;
        end
        if (bus.cap16_stb) begin
            s_d.cap16_hi = bus.cap16_val[15:8];
            s_d.cap16_lo = bus.cap16_val[7:0];
        end
        if (bus.cap8_hi_stb) begin
            s_d.cap8_hi = bus.cap8_val;
        end
        if (bus.cap8_lo_stb) begin
            s_d.cap8_lo = bus.cap8_val;
        end
        // Read data registered; reading changes nothing else
        if (bus.rd_en) begin
            case (bus.offset)
                `OFS_HOLD16_HI: s_d.rdata = s_q.hold16_hi;
                `OFS_CAP16_LO:  s_d.rdata = s_q.cap16_lo;
                `OFS_CAP16_HI:  s_d.rdata = s_q.cap16_hi;
                `OFS_CAP8_LO:   s_d.rdata = s_q.cap8_lo;
                `OFS_CAP8_HI:   s_d.rdata = s_q.cap8_hi;
                default:        s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '{hold16_hi: `HOLD_RESET, cap16_lo: `CAP_RESET, cap16_hi: `CAP_RESET,
                     cap8_lo: `CAP_RESET, cap8_hi: `CAP_RESET, rdata: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_cap_write_ignored: assert property ((bus.wr_en && bus.offset == `OFS_CAP16_LO && !bus.cap16_stb)
        |=> $stable(s_q.cap16_lo)) else $error("capture byte changed by write");
    a_hold_write: assert property ((bus.wr_en && bus.offset == `OFS_HOLD16_HI)
        |=> s_q.hold16_hi == $past(bus.wdata)) else $error("hold byte not written");
    a_cap8_high: assert property (bus.cap8_hi_stb
        |=> s_q.cap8_hi == $past(bus.cap8_val)) else $error("high phase not captured");
    a_cap8_low: assert property (bus.cap8_lo_stb
        |=> s_q.cap8_lo == $past(bus.cap8_val)) else $error("low phase not captured");
    a_cap16_pair: assert property (bus.cap16_stb
        |=> {s_q.cap16_hi, s_q.cap16_lo} == $past(bus.cap16_val)) else $error("capture pair wrong");
    a_read_no_effect: assert property ((bus.rd_en && !bus.wr_en && !bus.cap16_stb && !bus.cap8_hi_stb
        && !bus.cap8_lo_stb) |=> $stable(s_q.cap16_hi) && $stable(s_q.hold16_hi))
        else $error("read disturbed storage");
    c_hold_write: cover property (bus.wr_en && bus.offset == `OFS_HOLD16_HI);
endmodule : capture_store

// [hw/timer_capture_registers.sv]
`timescale 1ns/100ps
`include "timer_capture_defines.svh"
// Behaviour
// - Pointer upper nibble selects working register group for short references.
// - Pointer lower nibble selects expanded bank; bank D exposes timer registers.
// - Offset 0BH captures eight-bit count taken while input was high.
// - Offset 0AH captures eight-bit count taken while input was low.
// - Offset 09H holds the sixteen-bit capture's upper byte.
// - Offset 08H holds the sixteen-bit capture's lower byte.
// - Writes to capture registers are ignored; reads return captured values.
// - Offset 07H is a read/write hold for the sixteen-bit initial upper byte.
// - Initial count zero counts the full range, wrapping to FFFFH.
// - The zero to FFFFH wrap is no timeout and no reload.
// - Demodulation edge stores complemented count and restarts from FFFFH.
module timer_capture_registers
    import timer_capture_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  cpu_addr,
    input  wire logic        cpu_short,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_rd_valid,
    output logic      [3:0]  reg_group,
    output logic      [7:0]  eff_addr,
    input  wire logic        cnt16_enable,
    input  wire logic        cnt16_demod,
    input  wire logic        cnt16_tick,
    input  wire logic        cnt16_edge,
    input  wire logic [7:0]  init_low,
    output logic      [15:0] cnt16_count,
    output logic             cnt16_timeout,
    output logic             cnt16_captured,
    input  wire logic        cnt8_cap_hi_stb,
    input  wire logic        cnt8_cap_lo_stb,
    input  wire logic [7:0]  cnt8_count
);
    main_s         s_q;
    main_s         s_d;
    logic          tmr_hit;
    logic          demod_edge;
    capture_bus_if bus ();

    capture_store u_store (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (bus)
    );

    // Short references land in the group picked by the pointer
    assign reg_group = s_q.bank_group_pointer[`PTR_GROUP_MSB:`PTR_GROUP_LSB];
    assign eff_addr  = cpu_short ? {reg_group, cpu_addr[3:0]} : cpu_addr;

    // Expanded window only reaches the timers while bank D is selected
    assign tmr_hit = (eff_addr[7:4] == `WINDOW_GROUP)
                   && (s_q.bank_group_pointer[`PTR_BANK_MSB:`PTR_BANK_LSB] == `TIMER_BANK);

    // A qualifying edge only counts once the counter is armed
    assign demod_edge = cnt16_enable && cnt16_demod && cnt16_edge && (s_q.st != ST_IDLE);

    // Storage requests
    assign bus.wr_en       = cpu_wr && tmr_hit;
    assign bus.rd_en       = cpu_rd && tmr_hit;
    assign bus.offset      = eff_addr[3:0];
    assign bus.wdata       = cpu_wdata;
    assign bus.cap16_stb   = demod_edge;
    assign bus.cap16_val   = ~s_q.count;
    assign bus.cap8_hi_stb = cnt8_cap_hi_stb;
    assign bus.cap8_lo_stb = cnt8_cap_lo_stb;
    assign bus.cap8_val    = cnt8_count;

    // Both read sources are registered, so the mux never adds a new path
    assign cpu_rdata    = s_q.rd_tmr ? bus.rdata : s_q.rd_local;
    assign cpu_rd_valid = s_q.rd_valid;
    assign cnt16_count    = s_q.count;
    assign cnt16_timeout  = s_q.timeout;
    assign cnt16_captured = s_q.captured;

    // Pointer, read path and the sixteen-bit counter
    always_comb begin
        s_d          = s_q;
        s_d.timeout  = 1'b0;
        s_d.captured = 1'b0;
        s_d.rd_valid = cpu_rd;
        s_d.rd_tmr   = cpu_rd && tmr_hit;
        if (cpu_wr && eff_addr == `PTR_ADDR) begin
            s_d.bank_group_pointer = cpu_wdata;
        end
        // Reads outside the timer bank; unmapped reads give zero
        if (cpu_rd) begin
            s_d.rd_local = (eff_addr == `PTR_ADDR) ? s_q.bank_group_pointer : 8'h00;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (cnt16_enable) begin
                    // Hold byte sampled at start; mid-load writes are the user's hazard
                    s_d.init  = {bus.hold16_hi, init_low};
                    s_d.count = {bus.hold16_hi, init_low};
                    s_d.st    = cnt16_demod ? ST_WAIT : ST_COUNT;
                end
            end
            ST_WAIT: begin
                if (!cnt16_enable) begin
                    s_d.st = ST_IDLE;
                end else if (demod_edge) begin
                    s_d.count    = `COUNT_FULL;
                    s_d.captured = 1'b1;
                    s_d.st       = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!cnt16_enable) begin
                    s_d.st = ST_IDLE;
                end else if (demod_edge) begin
                    s_d.count    = `COUNT_FULL;
                    s_d.captured = 1'b1;
                end else if (cnt16_tick) begin
                    if (s_q.count == `COUNT_LAST) begin
                        // Count of one as initial value would fire at once; not allowed
                        s_d.timeout = 1'b1;
                        s_d.count   = cnt16_demod ? `COUNT_FULL : s_q.init;
                    end else begin
                        // Zero steps to FFFFH quietly and keeps going down
                        s_d.count = s_q.count - `COUNT_LAST;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '{bank_group_pointer: `PTR_RESET, count: `COUNT_RESET, init: `COUNT_RESET, st: ST_IDLE,
                     timeout: 1'b0, captured: 1'b0, rd_tmr: 1'b0, rd_valid: 1'b0,
                     rd_local: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_short_group: assert property (cpu_short
        |-> eff_addr == {s_q.bank_group_pointer[7:4], cpu_addr[3:0]})
        else $error("short reference outside selected group");
    a_bank_window: assert property ((cpu_rd && !cpu_wr && eff_addr[7:4] == `WINDOW_GROUP
        && s_q.bank_group_pointer[3:0] != `TIMER_BANK) |=> cpu_rd_valid && cpu_rdata == 8'h00)
        else $error("timer visible in wrong bank");
    a_bank_read: assert property ((cpu_rd && !cpu_wr && tmr_hit && eff_addr[3:0] == `OFS_CAP16_HI
        && !bus.cap16_stb) |=> cpu_rdata == $past(u_store.s_q.cap16_hi))
        else $error("capture read mismatch");
    a_wrap_quiet: assert property ((s_q.st == ST_COUNT && cnt16_enable && cnt16_tick && !demod_edge
        && s_q.count == `COUNT_ZERO) |=> s_q.count == `COUNT_FULL && !cnt16_timeout)
        else $error("wrap raised timeout");
    a_full_range: assert property ((s_q.st == ST_COUNT && cnt16_enable && cnt16_tick && !demod_edge
        && s_q.count == `COUNT_ZERO) ##1 (cnt16_enable && cnt16_tick && !demod_edge)
        |=> s_q.count == 16'hfffe) else $error("count did not continue down");
    a_timeout_reload: assert property ((s_q.st == ST_COUNT && cnt16_enable && !cnt16_demod
        && cnt16_tick && !demod_edge && s_q.count == `COUNT_LAST) |=> cnt16_timeout && s_q.count == s_q.init)
        else $error("timeout reload wrong");
    // Checks the stored pair itself, not the strobe wiring
    a_demod_capture: assert property ((s_q.st == ST_COUNT && demod_edge)
        |=> {u_store.s_q.cap16_hi, u_store.s_q.cap16_lo} == ~$past(s_q.count)
        && s_q.count == `COUNT_FULL && cnt16_captured)
        else $error("demodulation capture wrong");
    a_read_count: assert property ((cpu_rd && !cpu_wr && !cnt16_tick && !demod_edge
        && s_q.st == ST_COUNT && cnt16_enable) |=> $stable(s_q.count))
        else $error("read moved counter");

    c_wrap: cover property (s_q.st == ST_COUNT && cnt16_tick && s_q.count == `COUNT_ZERO);
    c_timeout: cover property (cnt16_timeout);
    c_demod: cover property (s_q.st == ST_COUNT ##1 cnt16_captured);
endmodule : timer_capture_registers

// [test/timer_capture_registers_test.sv]
`timescale 1ns/100ps
module timer_capture_registers_test
    import timer_capture_pkg::*;
;
    logic        clk_sys;
    logic        rst;
    logic [7:0]  cpu_addr;
    logic        cpu_short;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [7:0]  cpu_wdata;
    logic [7:0]  cpu_rdata;
    logic        cpu_rd_valid;
    logic [3:0]  reg_group;
    logic [7:0]  eff_addr;
    logic        cnt16_enable;
    logic        cnt16_demod;
    logic        cnt16_tick;
    logic        cnt16_edge;
    logic [7:0]  init_low;
    logic [15:0] cnt16_count;
    logic        cnt16_timeout;
    logic        cnt16_captured;
    logic        cnt8_cap_hi_stb;
    logic        cnt8_cap_lo_stb;
    logic [7:0]  cnt8_count;
    int          n_mismatch = 0;
    int          checks = 0;
    logic        seen;

    timer_capture_registers u_timer_capture_registers (
        .clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .cpu_short(cpu_short), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rd_valid(cpu_rd_valid),
        .reg_group(reg_group), .eff_addr(eff_addr), .cnt16_enable(cnt16_enable), .cnt16_demod(cnt16_demod),
        .cnt16_tick(cnt16_tick), .cnt16_edge(cnt16_edge), .init_low(init_low), .cnt16_count(cnt16_count),
        .cnt16_timeout(cnt16_timeout), .cnt16_captured(cnt16_captured), .cnt8_cap_hi_stb(cnt8_cap_hi_stb),
        .cnt8_cap_lo_stb(cnt8_cap_lo_stb), .cnt8_count(cnt8_count));

    // 10 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe, launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        @(negedge clk_sys);
        cpu_wr    = 1'b0;
    endtask : wr

    // Read answer lands one cycle after the strobe edge
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(negedge clk_sys);
        cpu_rd   = 1'b0;
        chk(cpu_rd_valid, 1'b1);
        chk(cpu_rdata, exp);
    endtask : rdchk

    // Pulse tick (0) or edge (1); flag may land in either of two cycles
    task automatic pulse(input int sel, input logic [15:0] cnt_exp, output logic hit);
        @(negedge clk_sys);
        if (sel == 0) cnt16_tick = 1'b1;
        else cnt16_edge = 1'b1;
        @(negedge clk_sys);
        cnt16_tick = 1'b0;
        cnt16_edge = 1'b0;
        chk(cnt16_count, cnt_exp);
        // Plain OR so an unknown flag stays unknown and fails the compare
        hit = (sel == 0) ? cnt16_timeout : cnt16_captured;
        @(negedge clk_sys);
        hit = hit | ((sel == 0) ? cnt16_timeout : cnt16_captured);
    endtask : pulse

    // Start counting from hold:init_low; hold only written while stopped
    task automatic start(input logic [7:0] hi, input logic [7:0] lo, input logic demod);
        @(negedge clk_sys);
        cnt16_enable = 1'b0;
        @(negedge clk_sys);
        wr(8'h07, hi);
        init_low     = lo;
        cnt16_demod  = demod;
        cnt16_enable = 1'b1;
        @(negedge clk_sys);
        chk(cnt16_count, {hi, lo});
    endtask : start

    task automatic s_pointer();
        chk(reg_group, 4'h0);
        wr(8'hfd, 8'h5d);
        chk(reg_group, 4'h5);
        cpu_short = 1'b1;
        cpu_addr  = 8'h03;
        #1 chk(eff_addr, 8'h53);
        @(negedge clk_sys);
        cpu_short = 1'b0;
        wr(8'hfd, 8'h5c);
        rdchk(8'h07, 8'h00);
        wr(8'hfd, 8'h0d);
    endtask : s_pointer

    task automatic s_regs();
        rdchk(8'h07, 8'h00);
        wr(8'h07, 8'ha5);
        rdchk(8'h07, 8'ha5);
        for (int i = 8; i < 12; i++) begin
            wr(8'(i), 8'hff);
            rdchk(8'(i), 8'h00);
        end
        wr(8'hfd, 8'h0c);
        rdchk(8'h07, 8'h00);
        wr(8'hfd, 8'h0d);
        rdchk(8'h07, 8'ha5);
    endtask : s_regs

    task automatic s_cap8();
        @(negedge clk_sys);
        cnt8_count      = 8'h3c;
        cnt8_cap_hi_stb = 1'b1;
        @(negedge clk_sys);
        cnt8_count      = 8'hc3;
        cnt8_cap_hi_stb = 1'b0;
        cnt8_cap_lo_stb = 1'b1;
        @(negedge clk_sys);
        cnt8_cap_lo_stb = 1'b0;
        cnt8_count      = 8'h99;
        rdchk(8'h0b, 8'h3c);
        rdchk(8'h0b, 8'h3c);
        rdchk(8'h0a, 8'hc3);
        wr(8'h0b, 8'h00);
        rdchk(8'h0b, 8'h3c);
    endtask : s_cap8

    task automatic s_counter();
        start(8'h00, 8'h00, 1'b0);
        pulse(0, 16'hffff, seen);
        chk(seen, 1'b0);
        pulse(0, 16'hfffe, seen);
        chk(seen, 1'b0);
        start(8'h00, 8'h02, 1'b0);
        pulse(0, 16'h0001, seen);
        chk(seen, 1'b0);
        pulse(0, 16'h0002, seen);
        chk(seen, 1'b1);
    endtask : s_counter

    task automatic s_demod();
        start(8'h12, 8'h34, 1'b1);
        pulse(1, 16'hffff, seen);
        chk(seen, 1'b1);
        rdchk(8'h09, 8'hed);
        rdchk(8'h08, 8'hcb);
        pulse(0, 16'hfffe, seen);
        pulse(0, 16'hfffd, seen);
        pulse(0, 16'hfffc, seen);
        pulse(1, 16'hffff, seen);
        chk(seen, 1'b1);
        rdchk(8'h09, 8'h00);
        rdchk(8'h08, 8'h03);
        chk(cnt16_count, 16'hffff);
    endtask : s_demod

    // Hang guard, well above the hundred or so cycles used
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        {cpu_addr, cpu_short, cpu_wr, cpu_rd, cpu_wdata} = '0;
        {cnt16_enable, cnt16_demod, cnt16_tick, cnt16_edge, init_low} = '0;
        {cnt8_cap_hi_stb, cnt8_cap_lo_stb, cnt8_count} = '0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        s_pointer();
        s_regs();
        s_cap8();
        s_counter();
        s_demod();
        finish_test();
    end
endmodule : timer_capture_registers_test
